// ---- shared/ues_regs.svh ----
`ifndef UES_REGS_SVH
`define UES_REGS_SVH

// word offsets (byte addresses on the register bus)
`define UES_OFF_ERR_FLAG      6'h00
`define UES_OFF_ERR_EN        6'h04
`define UES_OFF_STATUS        6'h08
`define UES_OFF_CONTROL       6'h0C
`define UES_OFF_IRQ_STATUS    6'h10

// error flag / enable bit positions
`define UES_ERR_BIT_STUFF     7
`define UES_ERR_BUFFER        5
`define UES_ERR_TURNAROUND    4
`define UES_ERR_BYTE_ALIGN    3
`define UES_ERR_CRC16         2
`define UES_ERR_CRC5          1
`define UES_ERR_PIDCHECK      0
`define UES_ERR_IMPL_MASK     8'hBF

// control register fields
`define UES_CTL_SETUP_HOLD    5
`define UES_CTL_REMOTE_WAKE   2
`define UES_CTL_PINGPONG_CLR  1
`define UES_CTL_MODULE_EN     0
`define UES_CTL_IMPL_MASK     8'h25

// main interrupt status fields
`define UES_IRQ_TOKEN_DONE    3
`define UES_IRQ_ERROR         1

// status entry fields
`define UES_STAT_EP_HI        7
`define UES_STAT_EP_LO        4
`define UES_STAT_DIR          3
`define UES_STAT_ODD          2

// reset values
`define UES_RST_ERR_FLAG      8'h00
`define UES_RST_ERR_EN        8'h00
`define UES_RST_CONTROL       8'h00
`define UES_RST_PINGPONG      2'h0

// highest endpoint number and the double-buffered ones
`define UES_MAX_EP            4'h6
`define UES_PP_EP_FIRST       5

`endif

// ---- shared/ues_pkg.sv ----
package ues_pkg;
    typedef logic [7:0] ues_byte_t;

    typedef struct packed {
        logic [3:0] ep;
        logic       dir_in;
        logic       odd;
        logic [1:0] zero;
    } ues_stat_t;

    typedef enum logic [1:0] {
        UES_IDLE,
        UES_ANSWER
    } ues_bus_state_t;
endpackage

// ---- shared/ues_fifo_if.sv ----
`timescale 1ns/1ps
`default_nettype none
// push/pop carrier between the control slice and its status store
interface ues_fifo_if;
    import ues_pkg::*;
    logic      push;
    logic      pop;
    ues_byte_t push_data;
    ues_byte_t head_data;
    logic      head_valid;
    logic      full;

    modport ctrl
    (
        output push,
        output pop,
        output push_data,
        input  head_data,
        input  head_valid,
        input  full
    );
    modport store
    (
        input  push,
        input  pop,
        input  push_data,
        output head_data,
        output head_valid,
        output full
    );
endinterface
`default_nettype wire

// ---- src/ues_stat_fifo.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "ues_regs.svh"
module ues_stat_fifo
#(
    parameter int DEPTH = 4
)
(
    input  wire logic mclk,
    input  wire logic resetn,
    ues_fifo_if.store f
);
    import ues_pkg::*;

    localparam int AW = $clog2(DEPTH);

    initial
    begin
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
            $error("status store depth must be a power of two, at least 2");
    end

    ues_byte_t         mem_q [DEPTH];
    logic [AW-1:0]     wr_q;
    logic [AW-1:0]     rd_q;
    logic [AW:0]       cnt_q;
    ues_byte_t         head_q;

    // a push into a full store is dropped; pop of an empty one is ignored
    wire do_push = f.push && (cnt_q != (AW+1)'(DEPTH));
    wire do_pop  = f.pop && (cnt_q != '0);
    wire [AW-1:0] rd_next = do_pop ? rd_q + AW'(1) : rd_q;
    wire [AW:0]   cnt_d   = cnt_q + (AW+1)'(do_push) - (AW+1)'(do_pop);

    assign f.full       = (cnt_q == (AW+1)'(DEPTH));
    assign f.head_valid = (cnt_q != '0);
    assign f.head_data  = head_q;

    // storage array; no reset needed, guarded by the count
    always_ff @(posedge mclk)
    begin
        if (do_push)
            mem_q[wr_q] <= f.push_data;
    end

    // pointers and count
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end
        else
        begin
            wr_q  <= do_push ? wr_q + AW'(1) : wr_q;
            rd_q  <= rd_next;
            cnt_q <= cnt_d;
        end
    end

    // registered head; a push into an emptying store goes straight to the head
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            head_q <= 8'h00;
        else if (do_push && (cnt_q == '0 || (cnt_q == (AW+1)'(1) && do_pop)))
            head_q <= f.push_data;
        else if (do_pop)
            head_q <= mem_q[rd_next];
    end
endmodule
`default_nettype wire

// ---- src/ues_ctrl.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "ues_regs.svh"
// Overview of operation
// (R01) each error enable bit gates its own error source onto the error bit
// (R02) status entry only valid while token-done flag is set
// (R03) every finished descriptor use pushes a new status entry; code pushes only while module-enable is set
// (R04) status entries queue in a four-deep byte store
// (R05) clearing token-done advances the visible status to the next entry
// (R06) a valid next entry re-raises token-done at once
// (R07) status bits 7..4 hold the endpoint number 0..6
// (R08) status bit 3 is 1 for IN, 0 for OUT
// (R09) status bit 2 is 1 for odd bank, 0 for even
// (R10) setup token sets setup-hold and stops packet traffic
// (R11) software clears setup-hold, then token processing resumes
// (R12) remote-wake bit drives resume signaling while set
// (R13) software times the resume signaling, not this block
// (R14) writing pingpong-clear forces every ping-pong selector to even
// (R15) ping-pong clear touches only endpoints 5 and 6
// (R16) module-enable bit enables the controller; transceiver unaffected
// (R17) setting module-enable clears ping-pong selectors and resets engine
// (R18) enabled error flags OR into one main error bit
// (R19) error flags set on detect, clear only on write-one
// (R20) unused bits read zero and ignore writes
module ues_ctrl
#(
    parameter int FIFO_DEPTH = 4
)
(
    input  wire logic              mclk,
    input  wire logic              resetn,
    // avalon-mm slave
    input  wire logic [5:0]        avs_address,
    input  wire logic              avs_read,
    input  wire logic              avs_write,
    input  wire logic [31:0]       avs_writedata,
    input  wire logic [3:0]        avs_byteenable,
    output logic [31:0]            avs_readdata,
    output logic                   avs_waitrequest,
    // serial engine side
    input  wire logic [7:0]        err_detect,
    input  wire logic              desc_done,
    input  wire logic [3:0]        desc_endpoint_number,
    input  wire logic              desc_dir_in,
    input  wire logic              desc_odd,
    input  wire logic              setup_token_seen,
    input  wire logic [1:0]        pingpong_toggle,
    output logic                   token_done_irq,
    output logic                   error_irq,
    output logic                   engine_hold,
    output logic                   engine_enable,
    output logic                   engine_reset,
    output logic                   resume_drive,
    output logic [1:0]             pingpong_sel,
    output logic                   status_overflow
);
    import ues_pkg::*;

    initial
    begin
        if (FIFO_DEPTH != 4)
            $error("the status store is specified four entries deep");
    end

    // ------------------------------------------------------------
    // registers and the status store
    // ------------------------------------------------------------
    ues_byte_t          error_flag_q;
    ues_byte_t          error_irq_enable_q;
    ues_byte_t          usb_control_q;
    logic               token_done_flag_q;
    logic [1:0]         pingpong_q;
    logic [1:0]         pingpong_d;
    logic               overflow_q;
    ues_bus_state_t     bus_state_q;
    logic [31:0]        rdata_q;

    ues_fifo_if fifo ();

    ues_stat_fifo #(.DEPTH(FIFO_DEPTH)) u_store
    (
        .mclk   (mclk),
        .resetn (resetn),
        .f      (fifo.store)
    );

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    // one wait cycle per access keeps read data registered
    wire       access    = (avs_read || avs_write) && (bus_state_q == UES_IDLE);
    wire       wr_take   = avs_write && (bus_state_q == UES_ANSWER);
    wire       rd_take   = avs_read && (bus_state_q == UES_IDLE);
    wire       lane0     = avs_byteenable[0];
    wire [7:0] wbyte     = avs_writedata[7:0];
    wire       wr_flag   = wr_take && lane0 && (avs_address == `UES_OFF_ERR_FLAG);
    wire       wr_en     = wr_take && lane0 && (avs_address == `UES_OFF_ERR_EN);
    wire       wr_ctl    = wr_take && lane0 && (avs_address == `UES_OFF_CONTROL);
    wire       wr_irq    = wr_take && lane0 && (avs_address == `UES_OFF_IRQ_STATUS);

    assign avs_waitrequest = (avs_read || avs_write) && (bus_state_q == UES_IDLE);
    assign avs_readdata    = rdata_q;

    // two-state handshake
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            bus_state_q <= UES_IDLE;
        else
            bus_state_q <= access ? UES_ANSWER : UES_IDLE;
    end

    // ------------------------------------------------------------
    // error flags and enables
    // ------------------------------------------------------------
    // set wins over a simultaneous write-one clear
    wire [7:0] err_clr   = wr_flag ? wbyte : 8'h00;                       // R19
    wire [7:0] err_set   = err_detect & `UES_ERR_IMPL_MASK;               // R20
    wire [7:0] flag_d    = ((error_flag_q & ~err_clr) | err_set);         // R19

    assign error_irq = |(error_flag_q & error_irq_enable_q);             // R01 R18

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            error_flag_q       <= `UES_RST_ERR_FLAG;
            error_irq_enable_q <= `UES_RST_ERR_EN;
        end
        else
        begin
            error_flag_q <= flag_d;
            if (wr_en)
                error_irq_enable_q <= wbyte & `UES_ERR_IMPL_MASK;         // R20
        end
    end

    // ------------------------------------------------------------
    // transaction status queue
    // ------------------------------------------------------------
    ues_stat_t new_entry;
    assign new_entry.ep     = desc_endpoint_number;                       // R07
    assign new_entry.dir_in = desc_dir_in;                                // R08
    assign new_entry.odd    = desc_odd;                                   // R09
    assign new_entry.zero   = 2'b00;                                      // R20

    assign fifo.push      = desc_done && usb_control_q[`UES_CTL_MODULE_EN]; // R03 R04
    assign fifo.push_data = new_entry;
    // token-done clear by write-one retires the head entry
    wire tok_clear = wr_irq && wbyte[`UES_IRQ_TOKEN_DONE] && token_done_flag_q;
    assign fifo.pop = tok_clear;                                          // R05

    // the flag mirrors a valid head; after a pop it rises again next cycle
    // if another entry waits, so software always sees one entry per flag
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            token_done_flag_q <= 1'b0;
        else if (tok_clear)
            token_done_flag_q <= 1'b0;                                    // R05
        else
            token_done_flag_q <= fifo.head_valid;                         // R06
    end

    assign token_done_irq = token_done_flag_q;                            // R02

    // a completion lost to a full queue is reported, sticky until reset
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            overflow_q <= 1'b0;
        else if (fifo.push && fifo.full)
            overflow_q <= 1'b1;
    end

    assign status_overflow = overflow_q;

    // ------------------------------------------------------------
    // control register
    // ------------------------------------------------------------
    wire enable_rise = wr_ctl && wbyte[`UES_CTL_MODULE_EN]
                       && !usb_control_q[`UES_CTL_MODULE_EN];             // R17
    wire pp_clear    = wr_ctl && wbyte[`UES_CTL_PINGPONG_CLR];            // R14
    // setup token beats a software clear in the same cycle; software may only
    // clear the hold, so a stray 1 written to bit 5 never freezes the engine
    wire hold_set    = setup_token_seen && usb_control_q[`UES_CTL_MODULE_EN];
    wire hold_keep   = usb_control_q[`UES_CTL_SETUP_HOLD]
                       && !(wr_ctl && !wbyte[`UES_CTL_SETUP_HOLD]);

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            usb_control_q <= `UES_RST_CONTROL;
        else
        begin
            usb_control_q[`UES_CTL_SETUP_HOLD] <= hold_set | hold_keep;   // R10 R11
            if (wr_ctl)
            begin
                usb_control_q[`UES_CTL_REMOTE_WAKE] <= wbyte[`UES_CTL_REMOTE_WAKE]; // R12
                usb_control_q[`UES_CTL_MODULE_EN]   <= wbyte[`UES_CTL_MODULE_EN];   // R16
            end
        end
    end

    // ping-pong selectors of the double-buffered endpoints only
    always_comb
    begin
        pingpong_d = pingpong_q ^ pingpong_toggle;
        if (pp_clear || enable_rise)
            pingpong_d = `UES_RST_PINGPONG;                               // R14 R15 R17
    end

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            pingpong_q <= `UES_RST_PINGPONG;
        else
            pingpong_q <= pingpong_d;
    end

    assign pingpong_sel  = pingpong_q;                                    // R15
    assign engine_hold   = usb_control_q[`UES_CTL_SETUP_HOLD];            // R10 R11
    assign engine_enable = usb_control_q[`UES_CTL_MODULE_EN];             // R16
    assign engine_reset  = enable_rise;                                   // R17
    // level only: software owns the signaling time
    assign resume_drive  = usb_control_q[`UES_CTL_REMOTE_WAKE];           // R12 R13

    // ------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------
    // status reads zero unless token-done is up, so stale data never shows
    wire [7:0] stat_view = token_done_flag_q ? fifo.head_data : 8'h00;   // R02
    wire [7:0] irq_view  = {4'h0, token_done_flag_q, 1'b0, error_irq, 1'b0}; // R18
    wire [7:0] rd_byte   =
        (avs_address == `UES_OFF_ERR_FLAG)   ? error_flag_q :
        (avs_address == `UES_OFF_ERR_EN)     ? error_irq_enable_q :
        (avs_address == `UES_OFF_STATUS)     ? stat_view :
        (avs_address == `UES_OFF_CONTROL)    ? (usb_control_q & `UES_CTL_IMPL_MASK) :
        (avs_address == `UES_OFF_IRQ_STATUS) ? irq_view : 8'h00;          // R20

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            rdata_q <= 32'h0000_0000;
        else if (rd_take)
            rdata_q <= {24'h00_0000, rd_byte};
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence tok_cleared_s;
        tok_clear;
    endsequence

    sequence next_ready_s;
        fifo.head_valid;
    endsequence

    property tok_reassert_p;
        @(posedge mclk) disable iff (!resetn)
        tok_cleared_s ##1 next_ready_s |=> token_done_flag_q;
    endproperty

    tok_reassert_a: assert property (tok_reassert_p)                      // R06
        else $error("token-done not raised again for a queued entry");

    tok_drop_a: assert property (@(posedge mclk) disable iff (!resetn)   // R05
        tok_clear |=> !token_done_flag_q)
        else $error("token-done did not drop on clear");

    err_or_a: assert property (@(posedge mclk) disable iff (!resetn)     // R18
        (wr_en && |(wbyte & error_flag_q)) |=> error_irq)
        else $error("enabling a pending flag did not raise the error bit");

    err_sticky_a: assert property (@(posedge mclk) disable iff (!resetn) // R19
        err_detect[`UES_ERR_CRC5] |=> error_flag_q[`UES_ERR_CRC5])
        else $error("detected error did not set its flag");

    err_hold_a: assert property (@(posedge mclk) disable iff (!resetn)   // R19
        (error_flag_q[`UES_ERR_PIDCHECK] && !wr_flag) |=> error_flag_q[`UES_ERR_PIDCHECK])
        else $error("error flag cleared without a write");

    setup_hold_a: assert property (@(posedge mclk) disable iff (!resetn) // R10
        (setup_token_seen && engine_enable) |=> engine_hold)
        else $error("setup token did not hold the engine");

    pp_clear_a: assert property (@(posedge mclk) disable iff (!resetn)   // R14
        (pp_clear || enable_rise) |=> (pingpong_sel == 2'b00))
        else $error("ping-pong selectors not cleared");

    resume_lvl_a: assert property (@(posedge mclk) disable iff (!resetn) // R12
        (wr_ctl && wbyte[`UES_CTL_REMOTE_WAKE]) |=> resume_drive [*2])
        else $error("resume signaling not driven after set");

    stat_valid_a: assert property (@(posedge mclk) disable iff (!resetn) // R02
        token_done_flag_q |-> (fifo.head_valid && stat_view == fifo.head_data))
        else $error("token-done up without a valid status entry");

    unused_zero_a: assert property (@(posedge mclk) disable iff (!resetn) // R20
        error_irq_enable_q[6] == 1'b0 && (usb_control_q & ~`UES_CTL_IMPL_MASK) == 8'h00)
        else $error("unused bits became set");

    sequence hold_cleared_s;
        wr_ctl && !wbyte[`UES_CTL_SETUP_HOLD] && !hold_set;
    endsequence

    property hold_release_p;
        @(posedge mclk) disable iff (!resetn)
        hold_cleared_s |=> !engine_hold;
    endproperty

    hold_release_a: assert property (hold_release_p)                      // R11
        else $error("setup hold not released by software");

    ovf_set_a: assert property (@(posedge mclk) disable iff (!resetn)    // R04
        (fifo.push && fifo.full) |=> status_overflow)
        else $error("lost status entry not reported");
endmodule
`default_nettype wire

// ---- dv/ues_engine_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------
// serial engine stand-in facing the control slice
// ------------------------------------------
module ues_engine_model
(
    input  wire logic  mclk,
    input  wire logic  engine_hold,
    output logic [7:0] err_detect,
    output logic       desc_done,
    output logic [3:0] desc_endpoint_number,
    output logic       desc_dir_in,
    output logic       desc_odd,
    output logic       setup_token_seen,
    output logic [1:0] pingpong_toggle
);
    // quiet lines at time zero
    initial
    begin
        err_detect = 8'h00;
        desc_done = 1'b0;
        desc_endpoint_number = 4'h0;
        desc_dir_in = 1'b0;
        desc_odd = 1'b0;
        setup_token_seen = 1'b0;
        pingpong_toggle = 2'h0;
    end

    // one descriptor finished; fields scrambled after the pulse so stale data is never trusted
    task automatic finish(input logic [3:0] ep, input logic dir, input logic odd);
        int n;
        n = 0;
        while (engine_hold !== 1'b0 && n < 50)
        begin
            @(posedge mclk);
            n++;
        end
        @(posedge mclk);
        desc_done <= 1'b1;
        desc_endpoint_number <= ep;
        desc_dir_in <= dir;
        desc_odd <= odd;
        @(posedge mclk);
        desc_done <= 1'b0;
        desc_endpoint_number <= ~ep;
        desc_dir_in <= ~dir;
        desc_odd <= ~odd;
        @(negedge mclk);
    endtask

    // single-cycle event pulses: errors, setup token, ping-pong toggles
    task automatic pulse(input logic [7:0] e, input logic s, input logic [1:0] p);
        @(posedge mclk);
        err_detect <= e;
        setup_token_seen <= s;
        pingpong_toggle <= p;
        @(posedge mclk);
        err_detect <= 8'h00;
        setup_token_seen <= 1'b0;
        pingpong_toggle <= 2'h0;
        @(negedge mclk);
    endtask
endmodule
`default_nettype wire

// ---- dv/tb_usb_device_error_status_control.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "ues_regs.svh"
module tb_usb_device_error_status_control;
    logic        mclk;
    logic        resetn;
    logic [5:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [3:0]  avs_byteenable;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic [7:0]  err_detect;
    logic        desc_done;
    logic [3:0]  desc_endpoint_number;
    logic        desc_dir_in;
    logic        desc_odd;
    logic        setup_token_seen;
    logic [1:0]  pingpong_toggle;
    logic        token_done_irq;
    logic        error_irq;
    logic        engine_hold;
    logic        engine_enable;
    logic        engine_reset;
    logic        resume_drive;
    logic [1:0]  pingpong_sel;
    logic        status_overflow;
    int          fails;
    int          tests_run;
    int          rst_pulses;
    logic [31:0] q;
    logic [7:0]  m;
    int          eb [7] = '{7, 5, 4, 3, 2, 1, 0};
    logic [7:0]  st [5] = '{8'h08, 8'h64, 8'h5C, 8'h30, 8'h10};

    ues_ctrl #(.FIFO_DEPTH(4)) DUT
    (
        .mclk(mclk), .resetn(resetn), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .err_detect(err_detect), .desc_done(desc_done),
        .desc_endpoint_number(desc_endpoint_number), .desc_dir_in(desc_dir_in),
        .desc_odd(desc_odd), .setup_token_seen(setup_token_seen),
        .pingpong_toggle(pingpong_toggle), .token_done_irq(token_done_irq),
        .error_irq(error_irq), .engine_hold(engine_hold), .engine_enable(engine_enable),
        .engine_reset(engine_reset), .resume_drive(resume_drive),
        .pingpong_sel(pingpong_sel), .status_overflow(status_overflow)
    );

    ues_engine_model eng
    (
        .mclk(mclk), .engine_hold(engine_hold), .err_detect(err_detect),
        .desc_done(desc_done), .desc_endpoint_number(desc_endpoint_number),
        .desc_dir_in(desc_dir_in), .desc_odd(desc_odd),
        .setup_token_seen(setup_token_seen), .pingpong_toggle(pingpong_toggle)
    );

    // ------------------------------------------
    // clock, engine-reset pulse counter, watchdog
    // ------------------------------------------
    initial
    begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    always @(posedge mclk)
    begin
        if (engine_reset === 1'b1)
            rst_pulses++;
    end

    initial
    begin
        #2000000;
        fails++;
        end_sim();
    end

    // ------------------------------------------
    // bus access, compares, closing report
    // ------------------------------------------
    task automatic end_sim;
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // request held until a rising edge samples waitrequest low, released right
    // after it; ends on the next falling edge so callers see settled outputs
    task automatic bus(input logic wr, input logic [5:0] a, input logic [7:0] d,
                       input logic [3:0] be);
        int n;
        n = 0;
        @(posedge mclk);
        avs_address <= a;
        avs_writedata <= {24'h000000, d};
        avs_byteenable <= be;
        avs_read <= ~wr;
        avs_write <= wr;
        do
        begin
            @(posedge mclk);
            n++;
        end
        while (avs_waitrequest !== 1'b0 && n < 20);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (avs_waitrequest !== 1'b0)
        begin
            fails++;
            end_sim();
        end
        @(negedge mclk);
    endtask

    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        bus(1'b1, a, d, 4'hF);
    endtask

    task automatic chk_reg(input logic [5:0] a, input logic [7:0] exp);
        bus(1'b0, a, 8'h00, 4'hF);
        cmp(q, {24'h000000, exp});
    endtask

    // got is taken at the call, on the falling edge where every driver task ends
    task automatic chk_out(input logic [7:0] got, input logic [7:0] exp);
        cmp({24'h000000, got}, {24'h000000, exp});
    endtask

    task automatic wait_tok(input logic lvl);
        int n;
        n = 0;
        while (token_done_irq !== lvl && n < 10)
        begin
            @(negedge mclk);
            n++;
        end
        cmp({31'h0, token_done_irq}, {31'h0, lvl});
    endtask

    task automatic done_test(input string s);
        $display("test %s finished", s);
    endtask

    // ------------------------------------------
    // main sequence
    // ------------------------------------------
    initial
    begin
        fails = 0;
        tests_run = 0;
        rst_pulses = 0;
        resetn = 1'b0;
        avs_address = 6'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h00000000;
        avs_byteenable = 4'h0;
        repeat (6) @(posedge mclk);
        resetn <= 1'b1;
        chk_reg(`UES_OFF_ERR_FLAG, 8'h00);
        chk_reg(`UES_OFF_ERR_EN, 8'h00);
        chk_reg(`UES_OFF_CONTROL, 8'h00);
        chk_reg(`UES_OFF_STATUS, 8'h00);
        chk_reg(6'h14, 8'h00);
        done_test("reset");
        // each error source alone, first masked then enabled
        foreach (eb[i])
        begin
            m = 8'h01 << eb[i];
            wr(`UES_OFF_ERR_EN, 8'h00);
            eng.pulse(m, 1'b0, 2'h0);
            chk_reg(`UES_OFF_ERR_FLAG, m);
            chk_out({7'h0, error_irq}, 8'h00);
            wr(`UES_OFF_ERR_EN, m);
            chk_out({7'h0, error_irq}, 8'h01);
            chk_reg(`UES_OFF_IRQ_STATUS, 8'h02);
            wr(`UES_OFF_ERR_FLAG, m);
            chk_reg(`UES_OFF_ERR_FLAG, 8'h00);
            chk_out({7'h0, error_irq}, 8'h00);
        end
        eng.pulse(8'h40, 1'b0, 2'h0);
        chk_reg(`UES_OFF_ERR_FLAG, 8'h00);
        wr(`UES_OFF_ERR_EN, 8'hFF);
        chk_reg(`UES_OFF_ERR_EN, 8'hBF);
        bus(1'b1, `UES_OFF_ERR_EN, 8'h00, 4'h0);
        chk_reg(`UES_OFF_ERR_EN, 8'hBF);
        wr(`UES_OFF_ERR_EN, 8'h00);
        done_test("errors");
        // disabled block drops finished descriptors
        eng.finish(4'h2, 1'b1, 1'b0);
        chk_out({7'h0, token_done_irq}, 8'h00);
        wr(`UES_OFF_CONTROL, 8'h01);
        chk_out({7'h0, engine_enable}, 8'h01);
        chk_out({7'h0, rst_pulses == 1}, 8'h01);
        eng.pulse(8'h00, 1'b0, 2'h3);
        chk_out({6'h0, pingpong_sel}, 8'h03);
        wr(`UES_OFF_CONTROL, 8'h03);
        chk_out({6'h0, pingpong_sel}, 8'h00);
        chk_reg(`UES_OFF_CONTROL, 8'h01);
        eng.pulse(8'h00, 1'b0, 2'h1);
        wr(`UES_OFF_CONTROL, 8'h00);
        wr(`UES_OFF_CONTROL, 8'h01);
        chk_out({6'h0, pingpong_sel}, 8'h00);
        chk_out({7'h0, rst_pulses == 2}, 8'h01);
        done_test("control");
        // software times the resume signaling
        wr(`UES_OFF_CONTROL, 8'h05);
        chk_out({7'h0, resume_drive}, 8'h01);
        chk_reg(`UES_OFF_CONTROL, 8'h05);
        wr(`UES_OFF_CONTROL, 8'h01);
        chk_out({7'h0, resume_drive}, 8'h00);
        done_test("resume");
        // five finished descriptors into a four-deep queue
        foreach (st[i])
        begin
            if (i == 4)
                chk_out({7'h0, status_overflow}, 8'h00);
            eng.finish(st[i][7:4], st[i][3], st[i][2]);
        end
        chk_out({7'h0, status_overflow}, 8'h01);
        wait_tok(1'b1);
        for (int k = 0; k < 4; k++)
        begin
            chk_reg(`UES_OFF_STATUS, st[k]);
            chk_reg(`UES_OFF_IRQ_STATUS, 8'h08);
            wr(`UES_OFF_IRQ_STATUS, 8'h08);
            wait_tok(k < 3);
        end
        chk_reg(`UES_OFF_STATUS, 8'h00);
        done_test("status");
        // setup token freezes traffic until software releases it
        eng.pulse(8'h00, 1'b1, 2'h0);
        chk_out({7'h0, engine_hold}, 8'h01);
        chk_reg(`UES_OFF_CONTROL, 8'h21);
        wr(`UES_OFF_CONTROL, 8'h01);
        chk_out({7'h0, engine_hold}, 8'h00);
        eng.finish(4'h4, 1'b0, 1'b1);
        wait_tok(1'b1);
        chk_reg(`UES_OFF_STATUS, 8'h44);
        done_test("setup");
        end_sim();
    end
endmodule
`default_nettype wire
